// >>> design/fvs_pkg.sv
// Package for the volatile status-one logic of a serial flash.
// Assumes one core clock and a serial link clock from the host.
package fvs_pkg;

  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_WRITE_REGS = 8'h01;
  localparam logic [7:0] CMD_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_READ_STATUS_ONE = 8'h05;
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_READ_STATUS_TWO = 8'h07;
  localparam logic [7:0] CMD_CLEAR_FLAGS_A = 8'h30;
  localparam logic [7:0] CMD_CLEAR_FLAGS_B = 8'h82;
  localparam logic [7:0] CMD_READ_ANY_REG = 8'h65;
  localparam logic [7:0] CMD_WRITE_ANY_REG = 8'h71;
  localparam logic [7:0] CMD_SUSPEND_ERASE = 8'h75;
  localparam logic [7:0] CMD_SUSPEND_PROGRAM = 8'h85;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'hD8;
  localparam logic [7:0] CMD_WHOLE_ERASE_A = 8'hC7;
  localparam logic [7:0] CMD_WHOLE_ERASE_B = 8'h60;
  localparam logic [7:0] CMD_SOFT_RESET = 8'hF0;

  // ----------------------------------------
  // Register addresses and byte counts
  // ----------------------------------------
  localparam logic [23:0] ADDR_STATUS_ONE_NV = 24'h000000;
  localparam logic [23:0] ADDR_STATUS_ONE_V = 24'h800000;
  localparam logic [2:0] BYTES_CMD_ONLY = 3'h1;
  localparam logic [2:0] BYTES_WRITE_REGS = 3'h2;
  localparam logic [2:0] BYTES_ADDR = 3'h4;
  localparam logic [2:0] BYTES_ADDR_DATA = 3'h5;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_LOCK = 7;
  localparam int BIT_PROG_FAIL = 6;
  localparam int BIT_ERASE_FAIL = 5;
  localparam int BIT_PROTECT_HI = 4;
  localparam int BIT_PROTECT_LO = 2;
  localparam int BIT_WEL = 1;
  localparam int BIT_BUSY = 0;
  localparam int BIT_PROTECT_SOURCE = 3;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {OP_IDLE, OP_PROG, OP_ERASE, OP_BULK, OP_NVWR, OP_FAIL} fvs_op_t;

  typedef struct packed {
    logic start;
    logic suspend;
    fvs_op_t kind;
    logic [23:0] addr;
    logic [2:0] nv_bp;
  } fvs_op_req_t;

  typedef struct packed {
    logic [1:0] cs_s;
    logic [1:0] wp_s;
    logic cs_prev;
    logic init;
    logic write_enable_latch;
    logic busy;
    logic perr;
    logic eerr;
    logic [2:0] bpv;
    fvs_op_t kind;
    logic pend;
    logic [7:0] snap;
    logic [7:0] stat;
    logic [2:0] active_bp;
    fvs_op_req_t req;
  } fvs_core_t;

  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [6:0] shift;
  } fvs_frame_t;

  typedef struct packed {
    logic [4:0][7:0] bytes;
    logic [2:0] count;
  } fvs_cap_t;

  localparam fvs_core_t CORE_RST = '0;
  localparam fvs_frame_t FRAME_RST = '0;
  localparam fvs_cap_t CAP_RST = '0;

endpackage

// >>> design/fvs_status_one.sv
// Volatile status-one register with its command decode and serial link.
// Assumes an embedded-operation engine and non-volatile store on clk,
// and a host driving sck, cs_n and mosi in serial mode 0.
// How it works
// - Status one read by 05h and 65h
// - Bit 7 mirrors the non-volatile lock bit
// - Program failure or protected target sets bit 6
// - Fail flags cleared by 30h/82h, reloaded from non-volatile defaults by F0h
// - Erase failure or protected sector sets bit 5
// - Whole-array erase sets erase fail only when the engine reports failure
// - Source 0: write programs non-volatile protect bits
// - Source 1: write changes volatile protect bits only
// - Protect bits refuse program/erase in range
// - Whole erase only with protect bits zero
// - Writes, program, erase need latch set
// - Only 06h sets, 04h clears latch
// - Successful operation clears the latch
// - Latch zero after soft reset, loaded from non-volatile bit 1 after hardware reset
// - Busy high while an operation runs
// - Busy accepts only reads, suspend, clear, reset
// - Suspend accepted only during matching operation
// - Fail keeps busy until clear command or soft reset
// - Volatile register writes never touch busy
// - Lock with protect pin low blocks writes
// - Reset loads flags from non-volatile defaults
`timescale 1ns/1ps

module fvs_status_one (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic wp_n,
  input wire logic [7:0] status_one_nonvolatile,
  input wire logic [7:0] config_one_nonvolatile,
  input wire logic area_protected,
  input wire logic op_done,
  input wire logic op_fail,
  output fvs_pkg::fvs_op_req_t op_req,
  output logic [2:0] active_bp,
  output logic [7:0] status_one_volatile
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic is_clear_cmd(input logic [7:0] c);
    return (c == fvs_pkg::CMD_CLEAR_FLAGS_A) || (c == fvs_pkg::CMD_CLEAR_FLAGS_B);
  endfunction

  function automatic logic is_write_cmd(input logic [7:0] c);
    return (c == fvs_pkg::CMD_WRITE_REGS) || (c == fvs_pkg::CMD_WRITE_ANY_REG);
  endfunction

  // ----------------------------------------
  // Link domain: bit and byte framing
  // ----------------------------------------
  fvs_pkg::fvs_frame_t fr_reg, fr_next;
  fvs_pkg::fvs_cap_t cap_reg;
  fvs_pkg::fvs_core_t st_reg, st_next;
  logic link_rst;
  logic [7:0] rx_byte;
  logic read_sel;
  logic [23:0] cap_addr;

  assign link_rst = cs_n | ~resetn;
  assign rx_byte = {fr_reg.shift, mosi};
  assign cap_addr = {cap_reg.bytes[1], cap_reg.bytes[2], cap_reg.bytes[3]};

  always_comb begin
    fr_next = fr_reg;
    fr_next.bit_cnt = fr_reg.bit_cnt + 3'h1;
    fr_next.shift = rx_byte[6:0];
    if (fr_reg.bit_cnt == 3'h7 && fr_reg.byte_cnt != fvs_pkg::BYTES_ADDR_DATA) begin
      fr_next.byte_cnt = fr_reg.byte_cnt + 3'h1;
    end
  end

  always_ff @(posedge sck or posedge link_rst) begin
    if (link_rst) begin
      fr_reg <= fvs_pkg::FRAME_RST;
    end else begin
      fr_reg <= fr_next;
    end
  end

  // Captured bytes survive the frame end for the core to read
  always_ff @(posedge sck or negedge resetn) begin
    if (!resetn) begin
      cap_reg <= fvs_pkg::CAP_RST;
    end else if (fr_reg.bit_cnt == 3'h0 && fr_reg.byte_cnt == 3'h0) begin
      cap_reg.count <= 3'h0;
    end else if (fr_reg.bit_cnt == 3'h7 && fr_reg.byte_cnt != fvs_pkg::BYTES_ADDR_DATA) begin
      cap_reg.bytes[fr_reg.byte_cnt] <= rx_byte;
      cap_reg.count <= fr_reg.byte_cnt + 3'h1;
    end
  end

  // Snapshot is frozen by the core while the frame is open
  assign read_sel = (fr_reg.byte_cnt != 3'h0 && cap_reg.bytes[0] == fvs_pkg::CMD_READ_STATUS_ONE) ||
    (fr_reg.byte_cnt >= fvs_pkg::BYTES_ADDR && cap_reg.bytes[0] == fvs_pkg::CMD_READ_ANY_REG &&
    cap_addr == fvs_pkg::ADDR_STATUS_ONE_V);

  always_ff @(negedge sck or posedge link_rst) begin
    if (link_rst) begin
      miso <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      miso <= read_sel & st_reg.snap[~fr_reg.bit_cnt];
      miso_oe <= 1'b1;
    end
  end

  // ----------------------------------------
  // Core domain
  // ----------------------------------------
  logic frame_end;
  logic locked;
  logic [7:0] cmd;
  logic [7:0] wr_data;
  logic [2:0] cur_bp;
  logic bp_volatile;
  logic to_vol;
  logic to_nv;
  logic op_running;

  assign frame_end = st_reg.cs_s[1] & ~st_reg.cs_prev;
  assign cmd = cap_reg.bytes[0];
  assign bp_volatile = config_one_nonvolatile[fvs_pkg::BIT_PROTECT_SOURCE];
  assign locked = status_one_nonvolatile[fvs_pkg::BIT_LOCK] & ~st_reg.wp_s[1];
  assign wr_data = (cmd == fvs_pkg::CMD_WRITE_REGS) ? cap_reg.bytes[1] : cap_reg.bytes[4];
  assign cur_bp = bp_volatile ? st_reg.bpv :
    status_one_nonvolatile[fvs_pkg::BIT_PROTECT_HI:fvs_pkg::BIT_PROTECT_LO];
  assign to_vol = bp_volatile &&
    ((cmd == fvs_pkg::CMD_WRITE_REGS && cap_reg.count >= fvs_pkg::BYTES_WRITE_REGS) ||
    (cmd == fvs_pkg::CMD_WRITE_ANY_REG && cap_reg.count == fvs_pkg::BYTES_ADDR_DATA &&
    cap_addr == fvs_pkg::ADDR_STATUS_ONE_V));
  assign to_nv = !bp_volatile &&
    ((cmd == fvs_pkg::CMD_WRITE_REGS && cap_reg.count >= fvs_pkg::BYTES_WRITE_REGS) ||
    (cmd == fvs_pkg::CMD_WRITE_ANY_REG && cap_reg.count == fvs_pkg::BYTES_ADDR_DATA &&
    cap_addr == fvs_pkg::ADDR_STATUS_ONE_NV));
  assign op_running = st_reg.busy && !st_reg.pend && st_reg.kind != fvs_pkg::OP_FAIL &&
    st_reg.kind != fvs_pkg::OP_IDLE;

  always_comb begin
    st_next = st_reg;
    st_next.cs_s = {st_reg.cs_s[0], cs_n};
    st_next.wp_s = {st_reg.wp_s[0], wp_n};
    st_next.cs_prev = st_reg.cs_s[1];
    st_next.req.start = 1'b0;
    st_next.req.suspend = 1'b0;
    st_next.active_bp = cur_bp;
    if (!bp_volatile) begin
      st_next.bpv = status_one_nonvolatile[fvs_pkg::BIT_PROTECT_HI:fvs_pkg::BIT_PROTECT_LO];
    end
    if (!st_reg.init) begin
      st_next.init = 1'b1;
      st_next.busy = status_one_nonvolatile[fvs_pkg::BIT_BUSY];
      st_next.write_enable_latch = status_one_nonvolatile[fvs_pkg::BIT_WEL];
      st_next.perr = status_one_nonvolatile[fvs_pkg::BIT_PROG_FAIL];
      st_next.eerr = status_one_nonvolatile[fvs_pkg::BIT_ERASE_FAIL];
      st_next.bpv = status_one_nonvolatile[fvs_pkg::BIT_PROTECT_HI:fvs_pkg::BIT_PROTECT_LO];
    end else begin
      if (frame_end && cap_reg.count != 3'h0) begin
        if (is_clear_cmd(cmd)) begin
          st_next.perr = 1'b0;
          st_next.eerr = 1'b0;
          if (st_reg.kind == fvs_pkg::OP_FAIL) begin
            st_next.busy = 1'b0;
            st_next.kind = fvs_pkg::OP_IDLE;
          end
        end else if (cmd == fvs_pkg::CMD_SOFT_RESET) begin
          st_next.write_enable_latch = 1'b0;
          st_next.busy = status_one_nonvolatile[fvs_pkg::BIT_BUSY];
          st_next.perr = status_one_nonvolatile[fvs_pkg::BIT_PROG_FAIL];
          st_next.eerr = status_one_nonvolatile[fvs_pkg::BIT_ERASE_FAIL];
          st_next.bpv = status_one_nonvolatile[fvs_pkg::BIT_PROTECT_HI:fvs_pkg::BIT_PROTECT_LO];
          st_next.kind = fvs_pkg::OP_IDLE;
          st_next.pend = 1'b0;
        end else if (cmd == fvs_pkg::CMD_SUSPEND_ERASE) begin
          st_next.req.suspend = op_running &&
            (st_reg.kind == fvs_pkg::OP_ERASE || st_reg.kind == fvs_pkg::OP_BULK);
        end else if (cmd == fvs_pkg::CMD_SUSPEND_PROGRAM) begin
          st_next.req.suspend = op_running && st_reg.kind == fvs_pkg::OP_PROG;
        end else if (!st_reg.busy) begin
          if (cmd == fvs_pkg::CMD_WRITE_ENABLE) begin
            st_next.write_enable_latch = 1'b1;
          end else if (cmd == fvs_pkg::CMD_WRITE_DISABLE) begin
            st_next.write_enable_latch = 1'b0;
          end else if (st_reg.write_enable_latch) begin
            if (is_write_cmd(cmd) && !locked) begin
              if (to_vol) begin
                st_next.bpv = wr_data[fvs_pkg::BIT_PROTECT_HI:fvs_pkg::BIT_PROTECT_LO];
                st_next.write_enable_latch = 1'b0;
              end else if (to_nv) begin
                st_next.req.start = 1'b1;
                st_next.req.kind = fvs_pkg::OP_NVWR;
                st_next.req.nv_bp = wr_data[fvs_pkg::BIT_PROTECT_HI:fvs_pkg::BIT_PROTECT_LO];
                st_next.kind = fvs_pkg::OP_NVWR;
                st_next.busy = 1'b1;
              end
            end else if ((cmd == fvs_pkg::CMD_PROGRAM && cap_reg.count == fvs_pkg::BYTES_ADDR_DATA) ||
              (cmd == fvs_pkg::CMD_SECTOR_ERASE && cap_reg.count == fvs_pkg::BYTES_ADDR)) begin
              st_next.pend = 1'b1;
              st_next.busy = 1'b1;
              st_next.kind = (cmd == fvs_pkg::CMD_PROGRAM) ? fvs_pkg::OP_PROG : fvs_pkg::OP_ERASE;
              st_next.req.addr = cap_addr;
            end else if ((cmd == fvs_pkg::CMD_WHOLE_ERASE_A || cmd == fvs_pkg::CMD_WHOLE_ERASE_B) &&
              cap_reg.count == fvs_pkg::BYTES_CMD_ONLY && cur_bp == 3'h0) begin
              st_next.req.start = 1'b1;
              st_next.req.kind = fvs_pkg::OP_BULK;
              st_next.kind = fvs_pkg::OP_BULK;
              st_next.busy = 1'b1;
            end
          end
        end
      end
      // Protection check in the cycle the address is presented on op_req.addr
      if (st_reg.pend) begin
        st_next.pend = 1'b0;
        if (area_protected) begin
          st_next.kind = fvs_pkg::OP_FAIL;
          if (st_reg.kind == fvs_pkg::OP_PROG) begin
            st_next.perr = 1'b1;
          end else begin
            st_next.eerr = 1'b1;
          end
        end else begin
          st_next.req.start = 1'b1;
          st_next.req.kind = st_reg.kind;
        end
      end
      // Completion; a fail wins over a clear in the same cycle
      if (op_done && op_running) begin
        if (op_fail) begin
          st_next.kind = fvs_pkg::OP_FAIL;
          st_next.busy = 1'b1;
          if (st_reg.kind == fvs_pkg::OP_ERASE || st_reg.kind == fvs_pkg::OP_BULK) begin
            st_next.eerr = 1'b1;
          end else begin
            st_next.perr = 1'b1;
          end
        end else begin
          st_next.busy = 1'b0;
          st_next.write_enable_latch = 1'b0;
          st_next.kind = fvs_pkg::OP_IDLE;
        end
      end
    end
    st_next.stat = {status_one_nonvolatile[fvs_pkg::BIT_LOCK], st_next.perr, st_next.eerr,
      st_next.bpv, st_next.write_enable_latch, st_next.busy};
    if (st_reg.cs_s[1]) begin
      st_next.snap = st_next.stat;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= fvs_pkg::CORE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign op_req = st_reg.req;
  assign active_bp = st_reg.active_bp;
  assign status_one_volatile = st_reg.stat;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_lock_copy: assert property (st_reg.init |=> status_one_volatile[7] == $past(status_one_nonvolatile[7]))
    else $error("status bit 7 does not follow the lock bit");
  a_prog_protect: assert property (st_reg.pend && st_reg.kind == fvs_pkg::OP_PROG && area_protected
    |=> st_reg.perr && st_reg.busy && !op_req.start) else $error("protected program not flagged");
  a_flag_clear: assert property ($fell(st_reg.perr) |-> $past(frame_end && (is_clear_cmd(cmd) ||
    cmd == fvs_pkg::CMD_SOFT_RESET))) else $error("program fail cleared without clear command");
  a_bulk_refuse: assert property (frame_end && cap_reg.count == 3'h1 && cmd == fvs_pkg::CMD_WHOLE_ERASE_A &&
    cur_bp != 3'h0 |=> !op_req.start ##1 !op_req.start) else $error("whole erase started while protected");
  a_wel_source: assert property ($past(st_reg.init) && $rose(st_reg.write_enable_latch) |->
    $past(frame_end && cmd == fvs_pkg::CMD_WRITE_ENABLE)) else $error("latch set by other command");
  a_wel_done: assert property (op_done && !op_fail && op_running |=> !st_reg.write_enable_latch && !st_reg.busy)
    else $error("latch or busy left set after success");
  a_busy_ignore: assert property (st_reg.init && st_reg.busy && frame_end && is_write_cmd(cmd)
    |=> $stable(st_reg.bpv) && !op_req.start) else $error("write accepted while busy");
  a_fail_busy: assert property (st_reg.init && st_reg.kind == fvs_pkg::OP_FAIL |-> st_reg.busy)
    else $error("busy dropped while a failure is pending");
  a_start_busy: assert property (op_req.start |-> st_reg.busy ##1 (st_reg.busy || $past(op_done)))
    else $error("operation started without busy");

  a_snap_freeze: assert property (!st_reg.cs_s[1] |=> $stable(st_reg.snap))
    else $error("status snapshot moved inside a frame");

  a_erase_protect: assert property (st_reg.pend && st_reg.kind == fvs_pkg::OP_ERASE && area_protected
    |=> st_reg.eerr && st_reg.busy && !op_req.start) else $error("protected erase not flagged");

  a_bulk_no_eerr: assert property (st_reg.init && st_reg.kind == fvs_pkg::OP_BULK && !op_done
    && !frame_end |=> !$rose(st_reg.eerr)) else $error("whole erase raised erase fail");

  a_start_clear: assert property (op_req.start &&
    (op_req.kind == fvs_pkg::OP_PROG || op_req.kind == fvs_pkg::OP_ERASE) |-> $past(!area_protected))
    else $error("start issued for a protected area");

  a_wel_needed: assert property (st_reg.init && frame_end && !st_reg.write_enable_latch |=> !op_req.start && !st_reg.pend)
    else $error("command accepted with the latch clear");

  a_wel_clear: assert property ($fell(st_reg.write_enable_latch) |-> $past(frame_end) || $past(op_done))
    else $error("latch cleared without a command or completion");

  a_soft_wel: assert property ($past(frame_end && cap_reg.count != 3'h0 && cmd == fvs_pkg::CMD_SOFT_RESET)
    |-> !st_reg.write_enable_latch) else $error("latch left set after software reset");

  a_reset_load: assert property (!st_reg.init |=>
    st_reg.busy == $past(status_one_nonvolatile[fvs_pkg::BIT_BUSY]) &&
    st_reg.write_enable_latch == $past(status_one_nonvolatile[fvs_pkg::BIT_WEL]) &&
    st_reg.perr == $past(status_one_nonvolatile[fvs_pkg::BIT_PROG_FAIL]) &&
    st_reg.eerr == $past(status_one_nonvolatile[fvs_pkg::BIT_ERASE_FAIL]))
    else $error("defaults not loaded after reset");

  a_susp_running: assert property (op_req.suspend |-> $past(op_running))
    else $error("suspend passed with no matching operation");

  a_vol_busy: assert property (st_reg.init && frame_end && to_vol && !st_reg.busy |=> !st_reg.busy)
    else $error("volatile write changed busy");

  a_lock_ignore: assert property (st_reg.init && frame_end && locked && bp_volatile && is_write_cmd(cmd)
    |=> $stable(st_reg.bpv) && !op_req.start) else $error("write accepted while locked");

  a_busy_refuse: assert property (st_reg.init && st_reg.busy && frame_end && !op_done &&
    (cmd == fvs_pkg::CMD_WRITE_ENABLE || cmd == fvs_pkg::CMD_WRITE_DISABLE) |=> $stable(st_reg.write_enable_latch))
    else $error("latch changed by a refused command");

  a_nv_follow: assert property (!bp_volatile |=>
    st_reg.bpv == $past(status_one_nonvolatile[fvs_pkg::BIT_PROTECT_HI:fvs_pkg::BIT_PROTECT_LO]))
    else $error("volatile protect bits do not follow the stored bits");

  a_vol_hold: assert property (st_reg.init && bp_volatile && !frame_end |=> $stable(st_reg.bpv))
    else $error("volatile protect bits moved without a write");

endmodule

// >>> testbench/fvs_host_model.sv
// Host side of the serial link: drives whole frames in mode 0.
// Assumes the device samples mosi on rising sck and shifts miso on falling sck.
`timescale 1ns/1ps

module fvs_host_model (
  output logic sck,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // ----------------------------------------
  // One frame, 12 ns link clock only inside it
  // ----------------------------------------
  task automatic xfer(input logic [39:0] tx, input int nbytes, output logic [7:0] rx);
    rx = 8'h00;
    #7 cs_n = 1'b0;
    #20;
    for (int i = 0; i < nbytes * 8; i++) begin
      mosi = tx[39 - i];
      #6 sck = 1'b1;
      rx = {rx[6:0], miso};
      #6 sck = 1'b0;
    end
    // Released line shows a changed level
    mosi = ~mosi;
    #10 cs_n = 1'b1;
    #200;
  endtask
endmodule

// >>> testbench/test_fvs_status_one.sv
// Bench for the volatile status-one logic.
// Assumes the host model on the link and an engine emulated here.
`timescale 1ns/1ps

module test_fvs_status_one;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic sck, cs_n, mosi, miso, miso_oe;
  logic wp_n = 1'b1;
  logic [7:0] nv = 8'h80;
  logic [7:0] cfg = 8'h08;
  logic prot = 1'b0;
  logic op_done = 1'b0;
  logic op_fail = 1'b0;
  fvs_pkg::fvs_op_req_t op_req;
  logic [2:0] active_bp;
  logic [7:0] status;
  logic eng_fail = 1'b0;
  logic [2:0] nv_bp_cap = 3'h0;
  logic [7:0] rx;
  logic oe_seen = 1'b0;
  int eng_cnt = 0;
  int starts = 0;
  int susps = 0;
  int bad_count = 0;
  int total_checks = 0;

  always #12.5 clk = ~clk;

  fvs_status_one i_dut (.clk(clk), .resetn(resetn), .sck(sck), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .wp_n(wp_n), .status_one_nonvolatile(nv),
    .config_one_nonvolatile(cfg), .area_protected(prot), .op_done(op_done), .op_fail(op_fail),
    .op_req(op_req), .active_bp(active_bp), .status_one_volatile(status));

  fvs_host_model i_host (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  // Output enable as seen at the last rising link edge of a frame
  always @(posedge sck) oe_seen <= miso_oe;

  // ----------------------------------------
  // Engine stand-in: 40-cycle operations
  // ----------------------------------------
  always @(posedge clk) begin
    op_done <= 1'b0;
    if (op_req.suspend) susps <= susps + 1;
    if (op_req.start) begin
      starts <= starts + 1;
      nv_bp_cap <= op_req.nv_bp;
      eng_cnt <= 40;
    end else if (eng_cnt == 1) begin
      op_done <= 1'b1;
      op_fail <= eng_fail;
      if (op_req.kind == fvs_pkg::OP_NVWR) nv[4:2] <= nv_bp_cap;
      eng_cnt <= 0;
    end else if (eng_cnt > 0) begin
      eng_cnt <= eng_cnt - 1;
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic send(input logic [39:0] tx, input int n);
    @(posedge clk);
    i_host.xfer(tx, n, rx);
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic cmd(input logic [7:0] code);
    send({code, 32'h0}, 1);
  endtask

  task automatic wr(input logic [7:0] data);
    send({fvs_pkg::CMD_WRITE_REGS, data, 24'h0}, 2);
  endtask

  task automatic rdsr(input logic [7:0] exp, input logic [7:0] mask);
    send({fvs_pkg::CMD_READ_STATUS_ONE, 32'h0}, 2);
    check(rx & mask, exp & mask);
    check(status & mask, exp & mask);
    check({7'h0, oe_seen}, 8'h01);
    check({7'h0, miso_oe}, 8'h00);
  endtask

  task automatic wait_bit(input int idx, input logic val);
    int k;
    for (k = 0; k < 300 && status[idx] !== val; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 300) begin
      bad_count++;
      end_of_test();
    end
  endtask

  initial begin
    #250000;
    bad_count++;
    end_of_test();
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    rdsr(8'h80, 8'hFF);
    send({fvs_pkg::CMD_READ_ANY_REG, fvs_pkg::ADDR_STATUS_ONE_V, 8'h0}, 5);
    check(rx, 8'h80);
    wr(8'hFF);
    rdsr(8'h80, 8'hFF);
    cmd(fvs_pkg::CMD_WRITE_ENABLE);
    rdsr(8'h82, 8'hFF);
    cmd(fvs_pkg::CMD_WRITE_DISABLE);
    rdsr(8'h80, 8'hFF);
    cmd(fvs_pkg::CMD_WRITE_ENABLE);
    wr(8'hFF);
    rdsr(8'h9C, 8'hFF);
    check({5'h0, active_bp}, 8'h07);
    @(posedge clk) prot <= 1'b1;
    cmd(fvs_pkg::CMD_WRITE_ENABLE);
    send({fvs_pkg::CMD_PROGRAM, 24'h000100, 8'hAA}, 5);
    rdsr(8'hDD, 8'hFD);
    wr(8'h00);
    cmd(fvs_pkg::CMD_WRITE_DISABLE);
    rdsr(8'hDF, 8'hFF);
    cmd(fvs_pkg::CMD_SUSPEND_PROGRAM);
    rdsr(8'hDD, 8'hFD);
    check(susps[7:0], 8'h00);
    cmd(fvs_pkg::CMD_CLEAR_FLAGS_A);
    cmd(fvs_pkg::CMD_WRITE_DISABLE);
    rdsr(8'h9C, 8'hFF);
    cmd(fvs_pkg::CMD_WRITE_ENABLE);
    send({fvs_pkg::CMD_SECTOR_ERASE, 24'h010000, 8'h0}, 4);
    rdsr(8'hBD, 8'hFD);
    cmd(fvs_pkg::CMD_CLEAR_FLAGS_B);
    cmd(fvs_pkg::CMD_WRITE_DISABLE);
    rdsr(8'h9C, 8'hFF);
    cmd(fvs_pkg::CMD_WRITE_ENABLE);
    cmd(fvs_pkg::CMD_WHOLE_ERASE_A);
    rdsr(8'h9E, 8'hFF);
    check(starts[7:0], 8'h00);
    wr(8'h00);
    rdsr(8'h80, 8'hFF);
    cmd(fvs_pkg::CMD_WRITE_ENABLE);
    cmd(fvs_pkg::CMD_WHOLE_ERASE_B);
    rdsr(8'h83, 8'hFF);
    wait_bit(0, 1'b0);
    rdsr(8'h80, 8'hFF);
    @(posedge clk) prot <= 1'b0;
    eng_fail <= 1'b1;
    cmd(fvs_pkg::CMD_WRITE_ENABLE);
    send({fvs_pkg::CMD_PROGRAM, 24'h000200, 8'h55}, 5);
    wait_bit(6, 1'b1);
    rdsr(8'hC1, 8'hFD);
    cmd(fvs_pkg::CMD_CLEAR_FLAGS_A);
    cmd(fvs_pkg::CMD_WRITE_DISABLE);
    rdsr(8'h80, 8'hFF);
    @(posedge clk) eng_fail <= 1'b0;
    cmd(fvs_pkg::CMD_WRITE_ENABLE);
    send({fvs_pkg::CMD_PROGRAM, 24'h000300, 8'h0F}, 5);
    cmd(fvs_pkg::CMD_SUSPEND_ERASE);
    check(susps[7:0], 8'h00);
    cmd(fvs_pkg::CMD_SUSPEND_PROGRAM);
    check(susps[7:0], 8'h01);
    check(op_req.addr[15:8], 8'h03);
    wait_bit(0, 1'b0);
    rdsr(8'h80, 8'hFF);
    @(posedge clk) cfg <= 8'h00;
    cmd(fvs_pkg::CMD_WRITE_ENABLE);
    wr(8'h0C);
    rdsr(8'h01, 8'h01);
    wait_bit(0, 1'b0);
    rdsr(8'h8C, 8'hFF);
    check({5'h0, active_bp}, 8'h03);
    @(posedge clk) cfg <= 8'h08;
    wp_n <= 1'b0;
    cmd(fvs_pkg::CMD_WRITE_ENABLE);
    wr(8'h00);
    rdsr(8'h8E, 8'hFF);
    @(posedge clk) wp_n <= 1'b1;
    nv[7] <= 1'b0;
    rdsr(8'h0E, 8'hFF);
    cmd(fvs_pkg::CMD_SOFT_RESET);
    rdsr(8'h0C, 8'hFF);
    @(posedge clk) nv <= 8'h4C;
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    rdsr(8'h4C, 8'hFF);
    end_of_test();
  end
endmodule
